// ### dv/idp_host_model.sv
`default_nettype none
// ****************************************
// Host adapter side: consumes the word stream
// ****************************************
module idp_host_model (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Behaviour control
   input  wire logic        slow,
   input  wire logic        clr,
   // Stream from the table
   input  wire logic        streamValid,
   input  wire logic [15:0] streamWord,
   input  wire logic [7:0]  streamIndex,
   output logic             streamReady
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] words [0:32];
   logic [7:0]  idxs  [0:32];
   int          count;
   logic [1:0]  phase;

   // Slow mode accepts one cycle in four, so held words get exercised;
   // ready stays low in reset so nothing is taken before a start
   always @(negedge core_clk)
   begin
      if (!nrst)
      begin
         phase       <= 2'h0;
         streamReady <= 1'b0;
      end
      else
      begin
         phase       <= phase + 2'h1;
         streamReady <= !slow || (phase == 2'h3);
      end
   end

   // Capture words in arrival order; overflow is dropped, not wrapped
   always @(posedge core_clk)
   begin
      if (clr || !nrst)
         count <= 0;
      else if (streamValid && streamReady && count < 33)
      begin
         words[count] <= streamWord;
         idxs[count]  <= streamIndex;
         count <= count + 1;
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // Starts low with no time-zero edge, so reset spans three rising edges
   logic core_clk = 1'b0;
   logic nrst, rdReq, modeWr, streamStart, slow, clr;
   logic [7:0]  rdIndex, streamIndex;
   logic [1:0]  modeSel, dmaMode;
   logic [15:0] rdData, streamWord;
   logic rdAck, rdMiss, streamReady, streamValid, streamLast, streamBusy;
   int fails, cmp_count;

   // ****************************************
   // Design, host model and clock
   // ****************************************
   idp_param_table dut (.core_clk(core_clk), .nrst(nrst), .rdReq(rdReq),
      .rdIndex(rdIndex), .rdData(rdData), .rdAck(rdAck), .rdMiss(rdMiss),
      .modeWr(modeWr), .modeSel(modeSel), .dmaMode(dmaMode),
      .streamStart(streamStart), .streamReady(streamReady),
      .streamWord(streamWord), .streamIndex(streamIndex),
      .streamValid(streamValid), .streamLast(streamLast),
      .streamBusy(streamBusy));
   idp_host_model model (.core_clk(core_clk), .nrst(nrst), .slow(slow),
      .clr(clr), .streamValid(streamValid), .streamWord(streamWord),
      .streamIndex(streamIndex), .streamReady(streamReady));

   initial
   begin
      forever #20 core_clk = !core_clk;
   end

   // ****************************************
   // Expected table and compares
   // ****************************************
   function automatic logic [15:0] expWord(int i, logic [1:0] m);
      case (i)
         51: return 16'h0200;
         53: return 16'h0003;
         63: return {5'h00, m == 2'h2, m == 2'h1, m == 2'h0, 8'h07};
         64: return 16'h0003;
         65, 66, 68: return 16'h0078;
         67: return 16'h017F;
         71: return 16'h07D0;
         72: return 16'h03E8;
         80: return 16'h0010;
         82: return 16'h4278;
         83: return 16'h4000;
         default: return 16'h0000;
      endcase
   endfunction

   task automatic chk16(string what, logic [15:0] e, logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk1(string what, logic e, logic g);
      chk16(what, {15'h0000, e}, {15'h0000, g});
   endtask

   task automatic summarize;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Back-to-back reads over a range, answers one cycle behind
   task automatic rdSweep(int lo, int hi, logic [1:0] m);
      @(negedge core_clk);
      rdReq = 1'b1;
      rdIndex = 8'(lo);
      for (int i = lo; i <= hi; i++)
      begin
         @(negedge core_clk);
         chk1("rdAck", 1'b1, rdAck);
         chk16("rdData", expWord(i, m), rdData);
         chk1("rdMiss", i < 51 || i > 83, rdMiss);
         if (i < hi)
            rdIndex = 8'(i + 1);
         else
            rdReq = 1'b0;
      end
      @(negedge core_clk);
      chk1("rdAck idle", 1'b0, rdAck);
   endtask

   // Every mode code; a read beside the write still sees the old mode,
   // the read held into the next cycle already sees the new one
   task automatic modeScan;
      logic [1:0] old;
      old = dmaMode;
      for (int m = 0; m < 4; m++)
      begin
         @(negedge core_clk);
         modeWr = 1'b1;
         modeSel = 2'(m);
         rdReq = 1'b1;
         rdIndex = 8'h3F;
         @(negedge core_clk);
         modeWr = 1'b0;
         chk16("word63 old mode", expWord(63, old), rdData);
         chk16("dmaMode", 16'(m), {14'h0000, dmaMode});
         @(negedge core_clk);
         rdReq = 1'b0;
         chk16("word63 new mode", expWord(63, 2'(m)), rdData);
         rdSweep(63, 63, 2'(m));
         old = 2'(m);
      end
   endtask

   // Whole stream into the host model; a start while busy is ignored
   task automatic runStream(logic s, logic [1:0] m);
      int n;
      @(negedge core_clk);
      slow = s;
      clr = 1'b1;
      streamStart = 1'b1;
      @(negedge core_clk);
      clr = 1'b0;
      streamStart = 1'b0;
      chk1("streamBusy", 1'b1, streamBusy);
      chk16("first index", 16'h0033, {8'h00, streamIndex});
      @(negedge core_clk);
      streamStart = 1'b1;
      @(negedge core_clk);
      streamStart = 1'b0;
      n = 0;
      while (streamBusy !== 1'b0 && n < 400)
      begin
         @(negedge core_clk);
         n++;
      end
      chk1("stream done", 1'b0, streamBusy);
      repeat (3) @(negedge core_clk);
      chk16("word count", 16'h0021, 16'(model.count));
      for (int i = 0; i < 33; i++)
      begin
         chk16("stream word", expWord(51 + i, m), model.words[i]);
         chk16("stream index", 16'(51 + i), {8'h00, model.idxs[i]});
      end
      chk1("streamLast", 1'b1, streamLast);
      chk1("streamValid", 1'b0, streamValid);
   endtask

   // Reset in mid-stream restores defaults
   task automatic midReset;
      @(negedge core_clk);
      modeWr = 1'b1;
      modeSel = 2'h1;
      streamStart = 1'b1;
      @(negedge core_clk);
      modeWr = 1'b0;
      streamStart = 1'b0;
      repeat (4) @(negedge core_clk);
      nrst = 1'b0;
      repeat (2) @(negedge core_clk);
      chk16("dmaMode reset", 16'h0002, {14'h0000, dmaMode});
      chk1("valid reset", 1'b0, streamValid);
      chk1("busy reset", 1'b0, streamBusy);
      chk16("index reset", 16'h0033, {8'h00, streamIndex});
      chk16("rdData reset", 16'h0000, rdData);
      nrst = 1'b1;
      rdSweep(63, 63, 2'h2);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial
   begin
      fails = 0;
      cmp_count = 0;
      nrst = 1'b0;
      rdReq = 1'b0;
      rdIndex = 8'h00;
      modeWr = 1'b0;
      modeSel = 2'h0;
      streamStart = 1'b0;
      slow = 1'b0;
      clr = 1'b0;
      repeat (3) @(negedge core_clk);
      nrst = 1'b1;
      chk16("dmaMode default", 16'h0002, {14'h0000, dmaMode});
      rdSweep(0, 0, 2'h2);
      rdSweep(50, 84, 2'h2);
      rdSweep(255, 255, 2'h2);
      modeScan();
      runStream(1'b0, 2'h3);
      @(negedge core_clk);
      modeWr = 1'b1;
      modeSel = 2'h0;
      @(negedge core_clk);
      modeWr = 1'b0;
      runStream(1'b1, 2'h0);
      midReset();
      summarize();
   end

   // Whole run is well under 2000 cycles
   initial
   begin
      #(40 * 5000);
      fails++;
      summarize();
   end
endmodule
`default_nettype wire

// ### rtl/idp_param_table.sv
// Contract
// - Word 51 reads 0200h, PIO timing mode high, low byte zero.
// - Word 53 reads 0003h, bit 2 clear unless Ultra-DMA exists.
// - Word 63 bits 10/9/8 show mode 2/1/0 while selected, 0407h default.
// - Word 63 low byte holds 07h, modes 0 to 2 supported.
// - Word 64 reads 0003h, flow-controlled PIO modes 3 and 4.
// - Words 65 and 66 read 0078h, 120 ns DMA cycle.
// - Word 67 reads 017Fh, 383 ns PIO cycle without flow control.
// - Word 68 reads 0078h, PIO cycle with ready-line flow control.
// - Word 71 reads 07D0h, 2000 us packet bus release time.
// - Word 72 reads 03E8h, 1000 us service busy clear time.
// - Word 80 reads 0010h and word 81 reads 0000h.
// - Word 82 reads 4278h, the supported command set.
// - Word 83 reads 4000h, bit 14 one, bit 15 and microcode zero.
`default_nettype none
module idp_param_table #(
   parameter bit UDMA_SUPPORTED = 1'b0
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Random word read
   input  wire logic        rdReq,
   input  wire logic [7:0]  rdIndex,
   output logic      [15:0] rdData,
   output logic             rdAck,
   output logic             rdMiss,
   // Multiword DMA mode selection
   input  wire logic        modeWr,
   input  wire logic [1:0]  modeSel,
   output logic      [1:0]  dmaMode,
   // Ascending word stream
   input  wire logic        streamStart,
   input  wire logic        streamReady,
   output logic      [15:0] streamWord,
   output logic      [7:0]  streamIndex,
   output logic             streamValid,
   output logic             streamLast,
   output logic             streamBusy
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [15:0]        rdWord;
   logic               rdInRange;
   logic [15:0]        stWord;
   logic [7:0]         next_streamIndex;
   logic               stAdvance;
   logic               stLoad;
   idp_pkg::idp_strm_e state;
   idp_pkg::idp_strm_e next_state;

   // ****************************************
   // Table lookups
   // ****************************************
   // Two copies so a random read never disturbs a running stream
   idp_word_rom #(
      .UDMA_SUPPORTED (UDMA_SUPPORTED)
   ) u_rom_rd (
      .wordIdx (rdIndex),
      .dmaMode (dmaMode),
      .wordVal (rdWord),
      .inRange (rdInRange)
   );

   idp_word_rom #(
      .UDMA_SUPPORTED (UDMA_SUPPORTED)
   ) u_rom_st (
      .wordIdx (next_streamIndex),
      .dmaMode (dmaMode),
      .wordVal (stWord),
      .inRange ()
   );

   // ****************************************
   // DMA mode register
   // ****************************************
   // Reset selects mode 2, giving the 0407h default of word 63
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         dmaMode <= idp_pkg::DMA_RESET;
      else if (modeWr)
         dmaMode <= modeSel;
   end

   // ****************************************
   // Random read port
   // ****************************************
   // Answer one cycle after the request; data holds until the next one
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         rdData <= idp_pkg::RSV_VAL;
         rdAck  <= 1'b0;
         rdMiss <= 1'b0;
      end
      else
      begin
         rdAck  <= rdReq;
         rdMiss <= rdReq && !rdInRange;
         if (rdReq)
            rdData <= rdWord;
      end
   end

   // ****************************************
   // Stream sequencer
   // ****************************************
   assign stAdvance = streamValid && streamReady;
   assign streamBusy = (state == idp_pkg::ST_RUN);

   // Next state and next index; start is ignored while running
   always_comb
   begin
      next_state       = state;
      next_streamIndex = streamIndex;
      stLoad           = 1'b0;
      case (state)
         idp_pkg::ST_IDLE:
         begin
            if (streamStart)
            begin
               next_state       = idp_pkg::ST_RUN;
               next_streamIndex = idp_pkg::IDX_FIRST;
               stLoad           = 1'b1;
            end
         end
         idp_pkg::ST_RUN:
         begin
            if (stAdvance && streamLast)
               next_state = idp_pkg::ST_IDLE;
            else if (stAdvance)
            begin
               next_streamIndex = streamIndex + idp_pkg::IDX_ONE;
               stLoad           = 1'b1;
            end
         end
         default:
            next_state = idp_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         state <= idp_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   // Word and index only move on load so data is stable under valid
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         streamIndex <= idp_pkg::IDX_FIRST;
         streamWord  <= idp_pkg::RSV_VAL;
         streamLast  <= 1'b0;
      end
      else if (stLoad)
      begin
         streamIndex <= next_streamIndex;
         streamWord  <= stWord;
         streamLast  <= (next_streamIndex == idp_pkg::IDX_LAST);
      end
   end

   // Valid rises on start and falls after the last word is taken
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         streamValid <= 1'b0;
      else if (state == idp_pkg::ST_IDLE)
         streamValid <= streamStart;
      else if (stAdvance && streamLast)
         streamValid <= 1'b0;
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // Helper: words accepted in the current stream before its last word
   logic [7:0] stCount;

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         stCount <= 8'h00;
      else if (stLoad && state == idp_pkg::ST_IDLE)
         stCount <= 8'h00;
      else if (stAdvance && !streamLast)
         stCount <= stCount + idp_pkg::IDX_ONE;
   end

   property p_word(logic [7:0] idx, logic [15:0] val);
      rdReq && rdIndex == idx |=> rdAck && !rdMiss && rdData == val;
   endproperty

   AST_W51: assert property (p_word(idp_pkg::IDX_FIRST,
                             idp_pkg::W51_VAL))
      else $error("word 51 value wrong");

   AST_W53: assert property (rdReq && rdIndex == idp_pkg::IDX_W53
      |=> rdData[15:3] == 13'h0000 && rdData[1:0] == 2'h3 &&
          rdData[2] == UDMA_SUPPORTED)
      else $error("word 53 value wrong");

   sequence s_mode_then_read63(logic [1:0] m);
      modeWr && modeSel == m ##1 (!modeWr && rdReq &&
                                  rdIndex == idp_pkg::IDX_W63);
   endsequence

   AST_W63_M2: assert property (
      s_mode_then_read63(idp_pkg::DMA_MODE2)
      |=> rdData == idp_pkg::W63_DFLT)
      else $error("word 63 mode 2 reading wrong");

   AST_W63_M0: assert property (
      s_mode_then_read63(idp_pkg::DMA_MODE0)
      |=> rdData[10:8] == idp_pkg::ACT_MODE0 && rdData[15:11] == 5'h00)
      else $error("word 63 mode 0 reading wrong");

   AST_W63_ACT: assert property (
      rdReq && rdIndex == idp_pkg::IDX_W63 && !modeWr
      |=> $countones(rdData[10:8]) == (dmaMode != idp_pkg::DMA_NONE))
      else $error("word 63 active bits not one-hot");

   AST_W63_SUPP: assert property (
      rdAck && $past(rdIndex) == idp_pkg::IDX_W63
      |-> rdData[7:0] == idp_pkg::W63_SUPP)
      else $error("word 63 support byte wrong");

   AST_W64: assert property (p_word(idp_pkg::IDX_W64,
                             idp_pkg::W64_VAL))
      else $error("word 64 value wrong");

   AST_W65: assert property (p_word(idp_pkg::IDX_W65,
                             idp_pkg::W65_VAL))
      else $error("word 65 value wrong");

   AST_W66: assert property (p_word(idp_pkg::IDX_W66,
                             idp_pkg::W66_VAL))
      else $error("word 66 value wrong");

   AST_W67: assert property (p_word(idp_pkg::IDX_W67,
                             idp_pkg::W67_VAL))
      else $error("word 67 value wrong");

   AST_W68: assert property (p_word(idp_pkg::IDX_W68,
                             idp_pkg::W68_VAL))
      else $error("word 68 value wrong");

   AST_W71: assert property (p_word(idp_pkg::IDX_W71,
                             idp_pkg::W71_VAL))
      else $error("word 71 value wrong");

   AST_W72: assert property (p_word(idp_pkg::IDX_W72,
                             idp_pkg::W72_VAL))
      else $error("word 72 value wrong");

   AST_W80: assert property (p_word(idp_pkg::IDX_W80,
                             idp_pkg::W80_VAL))
      else $error("word 80 value wrong");

   AST_W81: assert property (p_word(idp_pkg::IDX_W81,
                             idp_pkg::W81_VAL))
      else $error("word 81 value wrong");

   AST_W82: assert property (p_word(idp_pkg::IDX_W82,
                             idp_pkg::W82_VAL))
      else $error("word 82 value wrong");

   AST_W83: assert property (p_word(idp_pkg::IDX_LAST,
                             idp_pkg::W83_VAL))
      else $error("word 83 value wrong");

   AST_RESERVED: assert property (
      rdReq && (rdIndex == idp_pkg::IDX_W52 ||
                (rdIndex >= idp_pkg::IDX_W54 &&
                 rdIndex <= idp_pkg::IDX_W62) ||
                rdIndex == idp_pkg::IDX_W69 ||
                rdIndex == idp_pkg::IDX_W70 ||
                (rdIndex >= idp_pkg::IDX_W73 &&
                 rdIndex <= idp_pkg::IDX_W79))
      |=> rdData == idp_pkg::RSV_VAL && !rdMiss)
      else $error("reserved word not zero");

   AST_STREAM_ORDER: assert property (
      stAdvance && !streamLast
      |=> streamValid && streamIndex == $past(streamIndex) + 8'h01)
      else $error("stream index not ascending");

   AST_STREAM_LEN: assert property (
      stAdvance && streamLast
      |-> stCount == idp_pkg::WORD_SPAN &&
          streamIndex == idp_pkg::IDX_LAST ##1 !streamValid)
      else $error("stream length wrong");

   AST_STREAM_HOLD: assert property (
      streamValid && !streamReady |=> $stable(streamWord) &&
                                      $stable(streamIndex))
      else $error("stream word moved while stalled");

   COV_FULL_STREAM: cover property (stAdvance && streamLast);
   COV_MODE0_READ: cover property (
      s_mode_then_read63(idp_pkg::DMA_MODE0));
   COV_READ_MISS: cover property (rdMiss);
   COV_STALL: cover property ((streamValid && !streamReady) [*3]);

endmodule
`default_nettype wire

// ### rtl/idp_pkg.sv
`default_nettype none
package idp_pkg;

   // ****************************************
   // Word indices of the parameter table
   // ****************************************
   localparam logic [7:0] IDX_FIRST = 8'h33;  // Word 51
   localparam logic [7:0] IDX_W52   = 8'h34;
   localparam logic [7:0] IDX_W53   = 8'h35;
   localparam logic [7:0] IDX_W54   = 8'h36;
   localparam logic [7:0] IDX_W62   = 8'h3E;
   localparam logic [7:0] IDX_W63   = 8'h3F;
   localparam logic [7:0] IDX_W64   = 8'h40;
   localparam logic [7:0] IDX_W65   = 8'h41;
   localparam logic [7:0] IDX_W66   = 8'h42;
   localparam logic [7:0] IDX_W67   = 8'h43;
   localparam logic [7:0] IDX_W68   = 8'h44;
   localparam logic [7:0] IDX_W69   = 8'h45;
   localparam logic [7:0] IDX_W70   = 8'h46;
   localparam logic [7:0] IDX_W71   = 8'h47;
   localparam logic [7:0] IDX_W72   = 8'h48;
   localparam logic [7:0] IDX_W73   = 8'h49;
   localparam logic [7:0] IDX_W79   = 8'h4F;
   localparam logic [7:0] IDX_W80   = 8'h50;
   localparam logic [7:0] IDX_W81   = 8'h51;
   localparam logic [7:0] IDX_W82   = 8'h52;
   localparam logic [7:0] IDX_LAST  = 8'h53;  // Word 83
   localparam logic [7:0] IDX_ONE   = 8'h01;
   localparam logic [7:0] WORD_SPAN = 8'h20;  // Last minus first

   // ****************************************
   // Fixed word values
   // ****************************************
   localparam logic [15:0] W51_VAL  = 16'h0200;
   localparam logic [15:0] W53_VAL  = 16'h0003;
   localparam int          W53_UDMA = 2;      // Word 88 valid flag
   localparam logic [7:0]  W63_SUPP = 8'h07;  // Modes 0..2 supported
   localparam logic [4:0]  W63_RSVD = 5'h00;
   localparam logic [15:0] W63_DFLT = 16'h0407;
   localparam logic [15:0] W64_VAL  = 16'h0003;
   localparam logic [15:0] W65_VAL  = 16'h0078; // 120 ns
   localparam logic [15:0] W66_VAL  = 16'h0078; // 120 ns
   localparam logic [15:0] W67_VAL  = 16'h017F; // 383 ns
   localparam logic [15:0] W68_VAL  = 16'h0078;
   localparam logic [15:0] W71_VAL  = 16'h07D0; // 2000 us
   localparam logic [15:0] W72_VAL  = 16'h03E8; // 1000 us
   localparam logic [15:0] W80_VAL  = 16'h0010;
   localparam logic [15:0] W81_VAL  = 16'h0000;
   localparam logic [15:0] W82_VAL  = 16'h4278;
   localparam logic [15:0] W83_VAL  = 16'h4000;
   localparam logic [15:0] RSV_VAL  = 16'h0000;

   // ****************************************
   // Multiword DMA mode selection
   // ****************************************
   localparam logic [1:0] DMA_MODE0 = 2'h0;
   localparam logic [1:0] DMA_MODE1 = 2'h1;
   localparam logic [1:0] DMA_MODE2 = 2'h2;
   localparam logic [1:0] DMA_NONE  = 2'h3;
   localparam logic [1:0] DMA_RESET = 2'h2;
   localparam logic [2:0] ACT_MODE0 = 3'h1;
   localparam logic [2:0] ACT_MODE1 = 3'h2;
   localparam logic [2:0] ACT_MODE2 = 3'h4;
   localparam logic [2:0] ACT_NONE  = 3'h0;

   // Stream sequencer states
   typedef enum logic [0:0] {ST_IDLE, ST_RUN} idp_strm_e;

endpackage
`default_nettype wire

// ### rtl/idp_word_rom.sv
`default_nettype none
// Maps a word index to its table contents; purely combinational
module idp_word_rom #(
   parameter bit UDMA_SUPPORTED = 1'b0
) (
   // Lookup
   input  wire logic [7:0]  wordIdx,
   input  wire logic [1:0]  dmaMode,
   // Result
   output logic      [15:0] wordVal,
   output logic             inRange
);

   // ****************************************
   // Active mode bits of word 63
   // ****************************************
   logic [2:0] actBits;

   // One-hot of the selected mode, none for the spare code
   always_comb
   begin
      case (dmaMode)
         idp_pkg::DMA_MODE0: actBits = idp_pkg::ACT_MODE0;
         idp_pkg::DMA_MODE1: actBits = idp_pkg::ACT_MODE1;
         idp_pkg::DMA_MODE2: actBits = idp_pkg::ACT_MODE2;
         default:            actBits = idp_pkg::ACT_NONE;
      endcase
   end

   // ****************************************
   // Table lookup
   // ****************************************
   // Anything not listed is reserved and reads zero
   always_comb
   begin
      inRange = (wordIdx >= idp_pkg::IDX_FIRST) &&
                (wordIdx <= idp_pkg::IDX_LAST);
      wordVal = idp_pkg::RSV_VAL;
      case (wordIdx)
         idp_pkg::IDX_FIRST: wordVal = idp_pkg::W51_VAL;
         idp_pkg::IDX_W53:
         begin
            wordVal = idp_pkg::W53_VAL;
            wordVal[idp_pkg::W53_UDMA] = UDMA_SUPPORTED;
         end
         idp_pkg::IDX_W63:
            wordVal = {idp_pkg::W63_RSVD, actBits,
                       idp_pkg::W63_SUPP};
         idp_pkg::IDX_W64:  wordVal = idp_pkg::W64_VAL;
         idp_pkg::IDX_W65:  wordVal = idp_pkg::W65_VAL;
         idp_pkg::IDX_W66:  wordVal = idp_pkg::W66_VAL;
         idp_pkg::IDX_W67:  wordVal = idp_pkg::W67_VAL;
         idp_pkg::IDX_W68:  wordVal = idp_pkg::W68_VAL;
         idp_pkg::IDX_W71:  wordVal = idp_pkg::W71_VAL;
         idp_pkg::IDX_W72:  wordVal = idp_pkg::W72_VAL;
         idp_pkg::IDX_W80:  wordVal = idp_pkg::W80_VAL;
         idp_pkg::IDX_W81:  wordVal = idp_pkg::W81_VAL;
         idp_pkg::IDX_W82:  wordVal = idp_pkg::W82_VAL;
         idp_pkg::IDX_LAST: wordVal = idp_pkg::W83_VAL;
         default:           wordVal = idp_pkg::RSV_VAL;
      endcase
   end

endmodule
`default_nettype wire
